// ==== logic/drive_cyclic_io_mapper.sv ====
// Operation
// (R1) Output bytes 0-1 command word, 2-3 frequency reference, high byte first.
// (R2) Input bytes 0-1 status word, 2-3 motor speed, high byte first.
// (R3) Input bytes 4-5 torque reference monitor; bytes 6-7 reserved.
// (R4) Input bytes 8-9 active frequency reference, 10-11 output frequency.
// (R5) Input bytes 12-13 output current in hundredths of an ampere.
// (R6) Input bytes 14-15 analog input channel 1.
// (R7) Output bytes 10-11 analog output; drives terminal only with through-mode 000.
// (R8) Output bytes 14-15 digital outputs; terminals follow only with through-mode F.
// (R9) Message area layout shared by both directions, bytes 16 to 31.
// (R10) Voltage-per-frequency control reports zero motor speed.
// (R11) Torque monitor unusable when control method selection is 0.
// (R12) Bit 0: forward run, or run when command style is 1.
// (R13) Bit 1: reverse run, or direction select when command style is 1.
// (R14) Bits 2-6 drive multi-function inputs 3-7; bit 7 reserved.
// (R15) Bit 8 external fault, bit 9 fault reset, bit F baseblock.
// (R16) History reset only on a rising edge of its command bit.
// (R17) Status bits 0-7: run, zero speed, reverse, reset, agree, ready, alarm, fault.
// (R18) Status bits 8-E: error, power loss, net control, relay, OC1, OC2, motor 2.
// (R19) Commands reach the drive well within two milliseconds of reception.
// (R20) Reserved input bytes and bits read zero; reserved output content ignored.
`include "drive_map_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module drive_cyclic_io_mapper #(
	parameter int FWD_LIMIT_CYC = `FWD_LIMIT_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic rx_valid,
	input wire logic rx_first,
	input wire logic [7:0] rx_data,
	input wire logic tx_req,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic run_command_style_select,
	input wire logic [2:0] control_method_select,
	input wire logic [2:0] analog_out_function_select,
	input wire logic [7:0] relay_out_function_select,
	input wire logic [7:0] oc_out1_function_select,
	input wire logic [7:0] oc_out2_function_select,
	input wire drive_map_pkg::drive_status_monitor_s drive_status_monitor,
	input wire drive_map_pkg::monitor_s monitors,
	input wire drive_map_pkg::msg_s msg_reply,
	output drive_map_pkg::cmd_s cmd,
	output logic cmd_update,
	output logic [15:0] freq_ref,
	output logic [15:0] analog_out_value,
	output logic analog_out_net_active,
	output logic [15:0] digital_out_word,
	output logic relay_out,
	output logic oc_out1,
	output logic oc_out2,
	output drive_map_pkg::msg_s msg_cmd,
	output logic frame_dropped
);
	import drive_map_pkg::*;

	typedef struct packed {
		img_t rx_img;
		idx_t rx_idx;
		logic rx_active;
		logic [`TMO_W-1:0] rx_age;
		img_t tx_img;
		idx_t tx_idx;
		tx_state_e tx_state;
		logic tx_valid;
		logic [7:0] tx_data;
		logic tx_last;
		logic hist_bit;
		cmd_s cmd;
		logic cmd_update;
		logic [15:0] freq_ref;
		logic [15:0] ao_value;
		logic ao_active;
		logic [15:0] do_word;
		logic relay_out;
		logic oc_out1;
		logic oc_out2;
		msg_s msg_cmd;
		logic frame_dropped;
	} state_s;

	state_s q;
	state_s d;

	////////////////////////////////////////////////////////////////////////
	// Byte pair and selector helpers

	function automatic logic [15:0] get16(input img_t img, input idx_t off);
		get16 = {img[off], img[5'(off + `IDX_ONE)]};
	endfunction

	function automatic img_t put16(input img_t img, input idx_t off, input logic [15:0] v);
		img_t r;
		r = img;
		r[off] = v[15:8];
		r[5'(off + `IDX_ONE)] = v[7:0];
		put16 = r;
	endfunction

	function automatic logic through_f(input logic [7:0] sel);
		through_f = (sel == `DO_THROUGH);
	endfunction

	function automatic logic vf_mode(input logic [2:0] sel);
		vf_mode = (sel == `CTRL_VF);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next state

	img_t rx_next;
	img_t snap;
	logic [15:0] cw;
	logic [15:0] sw;
	logic commit;

	always_comb begin
		d = q;
		rx_next = q.rx_img;
		snap = '0;
		cw = `ZERO16;
		sw = `ZERO16;
		commit = 1'b0;
		d.cmd_update = 1'b0;
		d.frame_dropped = 1'b0;
		d.cmd.history_reset_pulse = 1'b0;

		// Receive side: collect one 32-byte image
		if (rx_valid && (rx_first || q.rx_active)) begin
			if (rx_first) begin
				rx_next[`IDX_ZERO] = rx_data;
				d.rx_idx = `IDX_ONE;
				d.rx_active = 1'b1;
				d.rx_age = '0;
			end else begin
				rx_next[q.rx_idx] = rx_data;
				d.rx_age = '0;
				d.rx_idx = 5'(q.rx_idx + `IDX_ONE);
				if (q.rx_idx == `IDX_LAST) begin
					d.rx_active = 1'b0;
					commit = 1'b1;
				end
			end
			d.rx_img = rx_next;
		end else if (q.rx_active) begin
			// (R19) stale frame dropped
			if (q.rx_age >= `TMO_W'(FWD_LIMIT_CYC - 1)) begin
				d.rx_active = 1'b0;
				d.frame_dropped = 1'b1;
			end else begin
				d.rx_age = `TMO_W'(q.rx_age + 1'b1);
			end
		end

		// Decode on the last byte so the drive sees it next cycle
		if (commit) begin
			// (R1) command and reference bytes
			cw = get16(rx_next, `OB_CMD);
			d.freq_ref = get16(rx_next, `OB_FREF);
			d.cmd_update = 1'b1;
			// (R12) run bit meaning
			// (R13) direction bit meaning
			if (run_command_style_select == `STYLE_RUN_DIR) begin
				d.cmd.forward_run_cmd = cw[`CB_RUN] & ~cw[`CB_DIR];
				d.cmd.reverse_run_cmd = cw[`CB_RUN] & cw[`CB_DIR];
				d.cmd.direction_select_cmd = cw[`CB_DIR];
			end else begin
				d.cmd.forward_run_cmd = cw[`CB_RUN];
				d.cmd.reverse_run_cmd = cw[`CB_DIR];
				d.cmd.direction_select_cmd = 1'b0;
			end
			// (R14) multi-function inputs 3-7
			d.cmd.mfdi_cmd = cw[`CB_MFDI_HI:`CB_MFDI_LO];
			// (R15) fault, reset, baseblock
			d.cmd.network_external_fault = cw[`CB_EF];
			d.cmd.fault_reset_cmd = cw[`CB_FRST];
			d.cmd.baseblock_cmd = cw[`CB_BB];
			// (R16) history reset edge
			d.cmd.history_reset_pulse = cw[`CB_HIST] & ~q.hist_bit;
			d.hist_bit = cw[`CB_HIST];
			// (R7) analog output through-mode
			d.ao_value = get16(rx_next, `OB_AO);
			d.ao_active = (analog_out_function_select == `AO_THROUGH);
			// (R8) digital output through-mode
			d.do_word = get16(rx_next, `OB_DO);
			d.relay_out = d.do_word[`DO_RELAY] & through_f(relay_out_function_select);
			d.oc_out1 = d.do_word[`DO_OC1] & through_f(oc_out1_function_select);
			d.oc_out2 = d.do_word[`DO_OC2] & through_f(oc_out2_function_select);
			// (R9) message area decode
			d.msg_cmd.func = rx_next[`MB_FUNC];
			d.msg_cmd.start_addr = get16(rx_next, `MB_ADDR);
			d.msg_cmd.count = rx_next[`MB_CNT];
			for (int i = 0; i < 4; i++) begin
				d.msg_cmd.data[i] = get16(rx_next, 5'(`MB_DATA + 2 * i));
			end
			d.msg_cmd.handshake = rx_next[`MB_HS];
			// (R20) reserved output bytes and bits not read
		end

		// Transmit side: snapshot the input image, then stream it
		// (R17) low status bits
		// (R18) high status bits
		sw = {1'b0, drive_status_monitor};
		// (R20) reserved status bit zero
		sw[`STAT_RSVD_BIT] = 1'b0;
		// (R2) status word and speed
		snap = put16(snap, `IB_STAT, sw);
		// (R10) zero speed under V/f
		snap = put16(snap, `IB_SPEED,
			vf_mode(control_method_select) ? `ZERO16 : monitors.motor_speed);
		// (R3) torque monitor
		// (R11) torque unusable under V/f
		snap = put16(snap, `IB_TORQ,
			vf_mode(control_method_select) ? `ZERO16 : monitors.torque_ref);
		// (R4) active reference and output frequency
		snap = put16(snap, `IB_FREF, monitors.freq_ref_active);
		snap = put16(snap, `IB_OFREQ, monitors.out_freq);
		// (R5) output current
		snap = put16(snap, `IB_CUR, monitors.out_current);
		// (R6) analog input 1
		snap = put16(snap, `IB_AI, monitors.analog_in1);
		// (R9) message reply area
		snap[`MB_FUNC] = msg_reply.func;
		snap = put16(snap, `MB_ADDR, msg_reply.start_addr);
		snap[`MB_CNT] = msg_reply.count;
		for (int i = 0; i < 4; i++) begin
			snap = put16(snap, 5'(`MB_DATA + 2 * i), msg_reply.data[i]);
		end
		snap[`MB_HS] = msg_reply.handshake;

		case (q.tx_state)
			TX_IDLE: begin
				if (tx_req) begin
					d.tx_img = snap;
					d.tx_idx = `IDX_ZERO;
					d.tx_state = TX_SEND;
					d.tx_valid = 1'b1;
					d.tx_data = snap[`IDX_ZERO];
					d.tx_last = 1'b0;
				end
			end
			TX_SEND: begin
				if (tx_ready) begin
					if (q.tx_idx == `IDX_LAST) begin
						d.tx_state = TX_IDLE;
						d.tx_valid = 1'b0;
						d.tx_last = 1'b0;
						d.tx_data = `ZERO8;
					end else begin
						d.tx_idx = 5'(q.tx_idx + `IDX_ONE);
						d.tx_data = q.tx_img[5'(q.tx_idx + `IDX_ONE)];
						d.tx_last = (5'(q.tx_idx + `IDX_ONE) == `IDX_LAST);
					end
				end
			end
			default: begin
				d.tx_state = TX_IDLE;
				d.tx_valid = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tx_valid = q.tx_valid;
	assign tx_data = q.tx_data;
	assign tx_last = q.tx_last;
	assign cmd = q.cmd;
	assign cmd_update = q.cmd_update;
	assign freq_ref = q.freq_ref;
	assign analog_out_value = q.ao_value;
	assign analog_out_net_active = q.ao_active;
	assign digital_out_word = q.do_word;
	assign relay_out = q.relay_out;
	assign oc_out1 = q.oc_out1;
	assign oc_out2 = q.oc_out2;
	assign msg_cmd = q.msg_cmd;
	assign frame_dropped = q.frame_dropped;
endmodule // drive_cyclic_io_mapper
`default_nettype wire

// ==== logic/drive_map_defines.svh ====
`ifndef DRIVE_MAP_DEFINES_SVH
`define DRIVE_MAP_DEFINES_SVH
// Image geometry
`define IMG_BYTES 32
`define IDX_LAST 5'h1F
`define IDX_ONE 5'h01
`define IDX_ZERO 5'h00
// Output image byte offsets, high byte first
`define OB_CMD 5'h00
`define OB_FREF 5'h02
`define OB_AO 5'h0A
`define OB_DO 5'h0E
// Message area, same in both directions
`define MB_FUNC 5'h10
`define MB_ADDR 5'h11
`define MB_CNT 5'h13
`define MB_DATA 5'h14
`define MB_HS 5'h1F
// Input image byte offsets, high byte first
`define IB_STAT 5'h00
`define IB_SPEED 5'h02
`define IB_TORQ 5'h04
`define IB_FREF 5'h08
`define IB_OFREQ 5'h0A
`define IB_CUR 5'h0C
`define IB_AI 5'h0E
// Command word bit positions
`define CB_RUN 0
`define CB_DIR 1
`define CB_MFDI_LO 2
`define CB_MFDI_HI 6
`define CB_EF 8
`define CB_FRST 9
`define CB_HIST 14
`define CB_BB 15
// Digital output word bits routed to terminals
`define DO_RELAY 0
`define DO_OC1 1
`define DO_OC2 2
// Selector codes
`define AO_THROUGH 3'h0
`define DO_THROUGH 8'h0F
`define CTRL_VF 3'h0
`define STYLE_RUN_DIR 1'b1
// Values
`define ZERO8 8'h00
`define ZERO16 16'h0000
`define STAT_RSVD_BIT 15
// Forwarding window for a partly received image
`define FWD_LIMIT_NS 2000000
`define CLK_PERIOD_NS 4
`define FWD_LIMIT_CYC (`FWD_LIMIT_NS / `CLK_PERIOD_NS)
`define TMO_W 20
`endif

// ==== logic/drive_map_pkg.sv ====
package drive_map_pkg;
	typedef logic [31:0][7:0] img_t;
	typedef logic [4:0] idx_t;
	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} tx_state_e;
	typedef struct packed {
		logic forward_run_cmd;
		logic reverse_run_cmd;
		logic direction_select_cmd;
		logic [4:0] mfdi_cmd;
		logic network_external_fault;
		logic fault_reset_cmd;
		logic history_reset_pulse;
		logic baseblock_cmd;
	} cmd_s;
	typedef struct packed {
		logic motor2_selected;
		logic oc_out2_closed;
		logic oc_out1_closed;
		logic relay_closed;
		logic network_control_flag;
		logic power_loss;
		logic operation_error_flag;
		logic fault;
		logic alarm;
		logic drive_ready;
		logic speed_agree;
		logic fault_reset_active;
		logic reverse_running;
		logic zero_speed;
		logic running;
	} drive_status_monitor_s;
	typedef struct packed {
		logic [15:0] motor_speed;
		logic [15:0] torque_ref;
		logic [15:0] freq_ref_active;
		logic [15:0] out_freq;
		logic [15:0] out_current;
		logic [15:0] analog_in1;
	} monitor_s;
	typedef struct packed {
		logic [7:0] func;
		logic [15:0] start_addr;
		logic [7:0] count;
		logic [3:0][15:0] data;
		logic [7:0] handshake;
	} msg_s;
endpackage

// ==== tb/mapper_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module mapper_properties (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic tx_req,
	input wire logic tx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire drive_map_pkg::cmd_s cmd,
	input wire logic cmd_update,
	input wire logic [15:0] freq_ref,
	input wire logic [15:0] digital_out_word,
	input wire logic relay_out,
	input wire logic analog_out_net_active,
	input wire logic frame_dropped
);
	import drive_map_pkg::*;
	logic [4:0] cnt_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 5'h00;
		end else if (tx_valid && tx_ready) begin
			cnt_q <= tx_last ? 5'h00 : cnt_q + 5'h01;
		end
	end
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("tx byte moved before handshake");
	a_tx_start: assert property (tx_req && !tx_valid |=> tx_valid)
		else $error("tx request not answered");
	a_tx_len: assert property (tx_valid && tx_last |-> cnt_q == 5'h1F)
		else $error("tx image not 32 bytes");
	a_tx_end: assert property (tx_valid && tx_last && tx_ready |=> !tx_valid)
		else $error("tx runs past last byte");
	a_idle_zero: assert property (!tx_valid |-> tx_data == 8'h00 && !tx_last)
		else $error("idle tx lines not zero");
	a_relay_gate: assert property (relay_out |-> digital_out_word[0])
		else $error("relay on without word bit");
	a_ao_commit: assert property ($changed(analog_out_net_active) |-> cmd_update)
		else $error("analog mode changed off commit");
	a_hist_pulse: assert property (cmd.history_reset_pulse |-> cmd_update ##1 !cmd.history_reset_pulse)
		else $error("history pulse malformed");
	a_drop_quiet: assert property (frame_dropped |-> !cmd_update ##1 $stable(freq_ref))
		else $error("dropped frame committed");
	a_freq_commit: assert property ($changed(freq_ref) |-> cmd_update)
		else $error("freq ref changed off commit");
	c_commit: cover property (cmd_update);
	c_drop: cover property (frame_dropped);
	c_tx_done: cover property (tx_valid && tx_last && tx_ready);
endmodule // mapper_properties
bind drive_cyclic_io_mapper mapper_properties u_props (.mclk(mclk), .rst_n(rst_n), .tx_req(tx_req),
	.tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .cmd(cmd),
	.cmd_update(cmd_update), .freq_ref(freq_ref), .digital_out_word(digital_out_word),
	.relay_out(relay_out), .analog_out_net_active(analog_out_net_active), .frame_dropped(frame_dropped));
`default_nettype wire

// ==== tb/fieldbus_master_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic send,
	input wire logic stall,
	input wire logic cut,
	input wire drive_map_pkg::img_t out_img,
	output logic rx_valid,
	output logic rx_first,
	output logic [7:0] rx_data,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready,
	output drive_map_pkg::img_t in_img
);
	import drive_map_pkg::*;
	logic ph;
	logic busy;
	logic [4:0] idx;
	logic [4:0] tidx;
	assign tx_ready = !stall || ph;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ph <= 1'b0;
			busy <= 1'b0;
			idx <= 5'h00;
			tidx <= 5'h00;
			rx_valid <= 1'b0;
			rx_first <= 1'b0;
			rx_data <= 8'h00;
			in_img <= '0;
		end else begin
			ph <= !ph;
			rx_valid <= 1'b0;
			rx_first <= 1'b0;
			rx_data <= ~rx_data;
			if (send && !busy) begin
				busy <= 1'b1;
				idx <= 5'h00;
			end else if (busy && tx_ready) begin
				rx_valid <= 1'b1;
				rx_first <= idx == 5'h00;
				rx_data <= out_img[5'h1F - idx];
				idx <= idx + 5'h01;
				busy <= idx != (cut ? 5'h03 : 5'h1F);
			end
			if (tx_valid && tx_ready) begin
				in_img[5'h1F - tidx] <= tx_data;
				tidx <= tx_last ? 5'h00 : tidx + 5'h01;
			end
		end
	end
endmodule // fieldbus_master_model
`default_nettype wire

// ==== tb/drive_cyclic_io_mapper_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module drive_cyclic_io_mapper_test;
	import drive_map_pkg::*;
	typedef struct packed {
		logic sty;
		logic [15:0] cmdw;
		logic [2:0] aos;
		logic [7:0] dsel;
		logic [15:0] dow;
		logic [1:0] run;
		logic hist;
	} row_s;
	localparam logic [127:0] OM = {8'h03, 16'h0102, 8'h08, 64'h1111_2222_3333_4444, 24'hFFFFFF, 8'h5A};
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic send = 1'b0;
	logic stall = 1'b0;
	logic cut = 1'b0;
	logic tx_req = 1'b0;
	logic sty = 1'b0;
	logic [2:0] ctrl = 3'h1;
	logic [2:0] aos = 3'h0;
	logic [7:0] dsel = 8'h0F;
	drive_status_monitor_s stat = 15'h4A53;
	monitor_s mon = 96'h1234_5678_9ABC_DEF0_0F1E_2D3C;
	msg_s rep = 104'h10_0203_04_5555_6666_7777_8888_A5;
	img_t out_img = '0;
	img_t in_img;
	logic rx_valid, rx_first, tx_ready, tx_valid, tx_last, cmd_update, ao_act;
	logic relay_out, oc_out1, oc_out2, frame_dropped;
	logic [7:0] rx_data, tx_data;
	logic [15:0] freq_ref, ao_val, do_word;
	cmd_s cmd;
	msg_s msg_cmd;
	int failures = 0;
	int cmp_count = 0;
	row_s rows [4] = '{'{1'b0, 16'hC083, 3'h0, 8'h0F, 16'h0005, 2'b11, 1'b1},
		'{1'b1, 16'h7F7E, 3'h1, 8'h0E, 16'h0007, 2'b00, 1'b0},
		'{1'b1, 16'h0003, 3'h0, 8'h0F, 16'h0002, 2'b01, 1'b0},
		'{1'b1, 16'h4201, 3'h2, 8'h0F, 16'hFFF8, 2'b10, 1'b1}};
	always #2 mclk = ~mclk;
	drive_cyclic_io_mapper #(.FWD_LIMIT_CYC(20)) DUT (.mclk(mclk), .rst_n(rst_n), .rx_valid(rx_valid),
		.rx_first(rx_first), .rx_data(rx_data), .tx_req(tx_req), .tx_ready(tx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .run_command_style_select(sty), .control_method_select(ctrl),
		.analog_out_function_select(aos), .relay_out_function_select(dsel), .oc_out1_function_select(dsel),
		.oc_out2_function_select(dsel), .drive_status_monitor(stat), .monitors(mon), .msg_reply(rep),
		.cmd(cmd), .cmd_update(cmd_update), .freq_ref(freq_ref), .analog_out_value(ao_val),
		.analog_out_net_active(ao_act), .digital_out_word(do_word), .relay_out(relay_out), .oc_out1(oc_out1),
		.oc_out2(oc_out2), .msg_cmd(msg_cmd), .frame_dropped(frame_dropped));
	fieldbus_master_model M (.mclk(mclk), .rst_n(rst_n), .send(send), .stall(stall), .cut(cut),
		.out_img(out_img), .rx_valid(rx_valid), .rx_first(rx_first), .rx_data(rx_data), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .in_img(in_img));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		if (failures == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input logic [255:0] seen, input logic [255:0] want);
		cmp_count++;
		if (seen !== want) begin
			failures++;
			$display("[ERR] %0t seen %0h want %0h", $time, seen, want);
		end
	endtask
	task automatic tick;
		@(posedge mclk);
	endtask
	task automatic await(input int sel);
		for (int n = 0; n < 300; n++) begin
			tick();
			#1;
			if ((sel == 0 && cmd_update === 1'b1) || (sel == 1 && frame_dropped === 1'b1)
				|| (sel == 2 && tx_valid === 1'b0)) return;
		end
		failures++;
		wrap_up();
	endtask
	function automatic img_t mk(input row_s r, input logic [15:0] f);
		return {r.cmdw, f, 48'hFFFF_FFFF_FFFF, f ^ 16'h0F0F, 16'hFFFF, r.dow, OM};
	endfunction
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		tick();
		#1;
		check({cmd, cmd_update, freq_ref, tx_valid, tx_data, frame_dropped}, '0);
		foreach (rows[i]) begin
			tick();
			sty <= rows[i].sty;
			aos <= rows[i].aos;
			dsel <= rows[i].dsel;
			stall <= i[0];
			out_img <= mk(rows[i], 16'h1000 + 16'(i));
			send <= 1'b1;
			tick();
			send <= 1'b0;
			await(0);
			check(cmd.history_reset_pulse, rows[i].hist);
			check({cmd.forward_run_cmd, cmd.reverse_run_cmd, cmd.direction_select_cmd},
				{rows[i].run, rows[i].sty & rows[i].cmdw[1]});
			check({cmd.mfdi_cmd, cmd.network_external_fault, cmd.fault_reset_cmd, cmd.baseblock_cmd},
				{rows[i].cmdw[6:2], rows[i].cmdw[8], rows[i].cmdw[9], rows[i].cmdw[15]});
			check(freq_ref, 16'h1000 + 16'(i));
			check({ao_act, ao_val}, {rows[i].aos == 3'h0, 16'h1F0F ^ 16'(i)});
			check({do_word, oc_out2, oc_out1, relay_out},
				{rows[i].dow, rows[i].dsel == 8'h0F ? rows[i].dow[2:0] : 3'h0});
			check(msg_cmd, {OM[127:96], OM[47:32], OM[63:48], OM[79:64], OM[95:80], OM[7:0]});
		end
		for (int k = 0; k < 2; k++) begin
			tick();
			ctrl <= k ? 3'h0 : 3'h1;
			stall <= k == 0;
			tick();
			tx_req <= 1'b1;
			tick();
			tx_req <= 1'b0;
			await(2);
			check(in_img, {1'b0, stat, k ? 32'h0 : mon[95:64], 16'h0, mon[63:0],
				rep.func, rep.start_addr, rep.count, rep.data[0], rep.data[1], rep.data[2], rep.data[3],
				24'h0, rep.handshake});
		end
		tick();
		cut <= 1'b1;
		out_img <= mk(rows[0], 16'hBEEF);
		send <= 1'b1;
		tick();
		send <= 1'b0;
		await(1);
		tick();
		#1;
		check(freq_ref, 16'h1003);
		tick();
		rst_n <= 1'b0;
		tick();
		tick();
		rst_n <= 1'b1;
		tick();
		#1;
		check({cmd, cmd_update, freq_ref, ao_act, ao_val, do_word, relay_out, oc_out1, oc_out2, msg_cmd}, '0);
		wrap_up();
	end
endmodule // drive_cyclic_io_mapper_test
`default_nettype wire
